// *** rtl/udr_map.svh ***
// register map, reset values and timing constants of the up/down reference ramp
`ifndef UDR_MAP_SVH
`define UDR_MAP_SVH

// byte offsets on the register bus
`define UDR_OFF_MODE 6'h00
`define UDR_OFF_INIT 6'h04
`define UDR_OFF_UP_SEL 6'h08
`define UDR_OFF_DOWN_SEL 6'h0C
`define UDR_OFF_RAMP 6'h10
`define UDR_OFF_LOWER 6'h14
`define UDR_OFF_UPPER 6'h18
`define UDR_OFF_HELD 6'h1C
`define UDR_OFF_CTRL 6'h20

// reset values
`define UDR_RST_MODE 2'h0
`define UDR_RST_INIT 16'h0000
`define UDR_RST_SEL 16'h0000
`define UDR_RST_RAMP 16'h0190
`define UDR_RST_LOWER 16'hFFCE
`define UDR_RST_UPPER 16'h0032
`define UDR_RST_CTRL 2'h0

// control register fields
`define UDR_CTRL_RUN 0
`define UDR_CTRL_THIS_SEL 1
`define UDR_STAT_UP 8
`define UDR_STAT_DOWN 9

// selector codes
`define UDR_SEL_ON 16'h0001
`define UDR_SEL_DI_LO 16'h0002
`define UDR_SEL_DI_HI 16'h0007
`define UDR_SEL_TF_LO 16'h0012
`define UDR_SEL_TF_HI 16'h0014
`define UDR_SEL_SV_LO 16'h0018
`define UDR_SEL_SV_HI 16'h001A

// timing: one ramp-time count is 0.1 s
`define UDR_RAMP_UNIT_NS 100000000
`define UDR_CLK_PERIOD_NS 25
`define UDR_RAMP_UNIT_CYC (`UDR_RAMP_UNIT_NS / `UDR_CLK_PERIOD_NS)

`endif

// *** rtl/udr_pkg.sv ***
// types shared by the up/down reference ramp
package udr_pkg;
    typedef enum logic [1:0] {
        UDR_OFF,
        UDR_INIT_STOP,
        UDR_RESUME,
        UDR_TRACK
    } udr_mode_t;
    typedef logic signed [15:0] udr_val_t;
endpackage : udr_pkg

// *** rtl/udr_src_sel.sv ***
// request source selector shared by the up and down paths
`timescale 1ns/100ps
`include "udr_map.svh"
module udr_src_sel import udr_pkg::*; (
    input wire logic [15:0] sel_code,
    input wire logic [5:0] delayed_input_status_word,
    input wire logic [2:0] timed_status,
    input wire logic [2:0] supervision_status,
    output logic req
);
    // range tests; reserved and unknown codes give no request
    wire in_di = sel_code >= `UDR_SEL_DI_LO && sel_code <= `UDR_SEL_DI_HI;
    wire in_tf = sel_code >= `UDR_SEL_TF_LO && sel_code <= `UDR_SEL_TF_HI;
    wire in_sv = sel_code >= `UDR_SEL_SV_LO && sel_code <= `UDR_SEL_SV_HI;
    wire [15:0] di_idx = sel_code - `UDR_SEL_DI_LO;
    wire [15:0] tf_idx = sel_code - `UDR_SEL_TF_LO;
    wire [15:0] sv_idx = sel_code - `UDR_SEL_SV_LO;
    wire di_bit = delayed_input_status_word[di_idx[2:0]];
    wire tf_bit = timed_status[tf_idx[1:0]];
    wire sv_bit = supervision_status[sv_idx[1:0]];
    assign req = (sel_code == `UDR_SEL_ON) | (in_di & di_bit) | (in_tf & tf_bit)
        | (in_sv & sv_bit);
endmodule : udr_src_sel

// *** rtl/udr_step_gen.sv ***
// fractional rate accumulator giving unit step pulses
`timescale 1ns/100ps
module udr_step_gen import udr_pkg::*; (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [16:0] span,
    input wire logic [39:0] period,
    output logic step
);
    logic [39:0] acc_q;
    logic [39:0] acc_d;
    wire [39:0] sum = acc_q + {23'h000000, span};
    wire hit = sum >= period;
    // remainder is kept so the mean rate is exactly span per period
    assign acc_d = !run ? 40'h0000000000 : (hit ? sum - period : sum);
    assign step = run & hit;
    // accumulator restarts whenever no ramp is under way
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            acc_q <= 40'h0000000000;
        end else begin
            acc_q <= acc_d;
        end
    end
endmodule : udr_step_gen

// *** rtl/udr_ramp_top.sv ***
// up/down reference ramp with its avalon-mm register slave
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "udr_map.svh"
module udr_ramp_top import udr_pkg::*; #(
    parameter int RAMP_UNIT_CYC = `UDR_RAMP_UNIT_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    // register bus, one wait state per transfer
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,

    // status inputs, synchronous to ref_clk
    input wire logic [5:0] delayed_input_status_word,
    input wire logic [2:0] timed_status,
    input wire logic [2:0] supervision_status,
    input wire logic [15:0] other_reference,
    output logic [15:0] held_reference
);

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // merge write data into a 16-bit register under byte enables
    // lanes 2 and 3 hold no register bits
    function automatic logic [15:0] be16(input logic [15:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
        be16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : be16

    // saturate a wide signed value into the limit window
    // spare bits stop a step past a limit from wrapping
    // inverted limits give the upper one above it, else the lower; upper tested first
    function automatic udr_val_t clamp(input logic signed [17:0] v, input udr_val_t lo,
                                       input udr_val_t hi);
        if (v > 18'(signed'(hi))) begin
            clamp = hi;
        end else if (v < 18'(signed'(lo))) begin
            clamp = lo;
        end else begin
            clamp = v[15:0];
        end
    endfunction : clamp

    ////////////////////////////////////////////////////////////////////////////
    // register state

    // software-visible configuration
    udr_mode_t mode_q;
    logic [15:0] init_q;
    logic [15:0] up_sel_q;
    logic [15:0] down_request_source_select_q;
    logic [15:0] ramp_time_setting_q;
    logic [15:0] lower_limit_value_q;
    logic [15:0] upper_limit_value_q;
    logic [1:0] ctrl_q;

    // held value and enable/stop edge detectors
    udr_val_t held_reference_output_q;
    udr_val_t held_d;
    udr_mode_t mode_prev_q;
    logic run_prev_q;

    // bus handshake and captured read word
    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave decode

    // one wait state: the answer comes in the cycle after the request appears
    wire req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_q;
    // a write commits once, in the answering cycle
    wire wr_go = avs_write & ack_q;

    // full compare: unaligned offsets hit nothing
    wire hit_mode = avs_address == `UDR_OFF_MODE;
    wire hit_init = avs_address == `UDR_OFF_INIT;
    wire hit_up = avs_address == `UDR_OFF_UP_SEL;
    wire hit_down = avs_address == `UDR_OFF_DOWN_SEL;
    wire hit_ramp = avs_address == `UDR_OFF_RAMP;
    wire hit_lower = avs_address == `UDR_OFF_LOWER;
    wire hit_upper = avs_address == `UDR_OFF_UPPER;
    wire hit_held = avs_address == `UDR_OFF_HELD;
    wire hit_ctrl = avs_address == `UDR_OFF_CTRL;

    // request routing
    // combinational from selectors and status words
    logic up_req;
    logic down_req;

    // read mux; unmapped offsets read as zero
    // ctrl also reports the live request pair
    always_comb begin
        rdata_d = 32'h00000000;
        if (hit_mode) begin
            rdata_d[1:0] = mode_q;
        end else if (hit_init) begin
            rdata_d[15:0] = init_q;
        end else if (hit_up) begin
            rdata_d[15:0] = up_sel_q;
        end else if (hit_down) begin
            rdata_d[15:0] = down_request_source_select_q;
        end else if (hit_ramp) begin
            rdata_d[15:0] = ramp_time_setting_q;
        end else if (hit_lower) begin
            rdata_d[15:0] = lower_limit_value_q;
        end else if (hit_upper) begin
            rdata_d[15:0] = upper_limit_value_q;
        end else if (hit_held) begin
            rdata_d[15:0] = held_reference_output_q;
        end else if (hit_ctrl) begin
            rdata_d[1:0] = ctrl_q;
            rdata_d[`UDR_STAT_UP] = up_req;
            rdata_d[`UDR_STAT_DOWN] = down_req;
        end
    end

    // from a flop, so steady while waitrequest is low
    assign avs_readdata = rdata_q;

    // handshake flop and registered read data
    // a request kept high after its answer counts
    // as a second transfer
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // configuration writes; the held value register has no write path
    // mode and ctrl sit in lane 0 only
    // held value is not writable
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode_q <= udr_mode_t'(`UDR_RST_MODE);
            init_q <= `UDR_RST_INIT;
            up_sel_q <= `UDR_RST_SEL;
            down_request_source_select_q <= `UDR_RST_SEL;
            ramp_time_setting_q <= `UDR_RST_RAMP;
            lower_limit_value_q <= `UDR_RST_LOWER;
            upper_limit_value_q <= `UDR_RST_UPPER;
            ctrl_q <= `UDR_RST_CTRL;
        end else if (wr_go) begin
            if (hit_mode && avs_byteenable[0]) begin
                mode_q <= udr_mode_t'(avs_writedata[1:0]);
            end
            if (hit_init) begin
                init_q <= be16(init_q, avs_writedata, avs_byteenable);
            end
            if (hit_up) begin
                up_sel_q <= be16(up_sel_q, avs_writedata, avs_byteenable);
            end
            if (hit_down) begin
                down_request_source_select_q <= be16(down_request_source_select_q,
                                                     avs_writedata, avs_byteenable);
            end
            if (hit_ramp) begin
                ramp_time_setting_q <= be16(ramp_time_setting_q, avs_writedata,
                                            avs_byteenable);
            end
            if (hit_lower) begin
                lower_limit_value_q <= be16(lower_limit_value_q, avs_writedata,
                                            avs_byteenable);
            end
            if (hit_upper) begin
                upper_limit_value_q <= be16(upper_limit_value_q, avs_writedata,
                                            avs_byteenable);
            end
            if (hit_ctrl && avs_byteenable[0]) begin
                ctrl_q <= avs_writedata[1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request sources

    // one status input may feed both paths
    // up request routing
    udr_src_sel u_up_sel (
        .sel_code(up_sel_q),
        .delayed_input_status_word(delayed_input_status_word),
        .timed_status(timed_status),
        .supervision_status(supervision_status),
        .req(up_req)
    );

    // same decoder serves the down path
    udr_src_sel u_down_sel (
        .sel_code(down_request_source_select_q),
        .delayed_input_status_word(delayed_input_status_word),
        .timed_status(timed_status),
        .supervision_status(supervision_status),
        .req(down_req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // rate generation

    udr_val_t lo;
    udr_val_t hi;
    assign lo = lower_limit_value_q;
    assign hi = upper_limit_value_q;
    // span and period follow the live registers;
    // an edit acts on the next accumulator update
    // span between limits; inverted limits give a zero span, so no steps
    wire signed [16:0] span_s = 17'(signed'(hi)) - 17'(signed'(lo));
    wire [16:0] span = span_s[16] ? 17'h00000 : span_s;
    // ramp counts of 0.1 s turned into clock cycles
    wire [39:0] period = 40'(ramp_time_setting_q) * 40'(RAMP_UNIT_CYC);

    // zero ramp time has no rate: jump to the limit
    wire ramp_zero = ramp_time_setting_q == 16'h0000;

    wire go_up = up_req & ~down_req;
    wire go_down = down_req & ~up_req;
    wire step;

    // one generator serves both directions at the same rate
    // accumulator restarts while no direction is active
    udr_step_gen u_step (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(go_up | go_down),
        .span(span),
        .period(period),
        .step(step)
    );

    ////////////////////////////////////////////////////////////////////////////
    // held value


    // enable is leaving mode zero; stop is run falling
    wire run_now = ctrl_q[`UDR_CTRL_RUN];
    wire this_sel = ctrl_q[`UDR_CTRL_THIS_SEL];
    wire enabling = (mode_q != UDR_OFF) & (mode_prev_q == UDR_OFF);
    wire stop_seen = run_prev_q & ~run_now;

    // steps run two bits wider, clamped back to 16
    wire signed [17:0] held_w = 18'(held_reference_output_q);
    wire signed [17:0] up_w = held_w + 18'sh00001;
    wire signed [17:0] down_w = held_w - 18'sh00001;

    // priority: off, initial load, tracking, ramp, re-clamp after limit edits
    // default re-clamps each cycle, so a limit edit
    // pulls the value inside on the next edge
    always_comb begin
        held_d = clamp(held_w, lo, hi);
        if (mode_q == UDR_OFF) begin
            held_d = 16'sh0000;
        end else if (enabling || (mode_q == UDR_INIT_STOP && stop_seen)) begin
            // initial value on enable, and on stop in mode UDR_INIT_STOP only
            held_d = clamp(18'(signed'(init_q)), lo, hi);
        end else if (mode_q == UDR_TRACK && !this_sel) begin
            // follow the other reference while it is in use
            // tracking outranks the ramp
            held_d = clamp(18'(signed'(other_reference)), lo, hi);
        end else if (go_up && (ramp_zero || step)) begin
            // rise, stopping exactly at the upper limit
            held_d = ramp_zero ? hi : clamp(up_w, lo, hi);
        end else if (go_down && (ramp_zero || step)) begin
            // fall, stopping exactly at the lower limit
            held_d = ramp_zero ? lo : clamp(down_w, lo, hi);
        end
    end

    // limits applied through the clamp on every update except in mode off and the zero ramp time jump
    // previous mode and run feed the edge detectors
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            held_reference_output_q <= 16'sh0000;
            mode_prev_q <= UDR_OFF;
            run_prev_q <= 1'b0;
        end else begin
            held_reference_output_q <= held_d;
            mode_prev_q <= mode_q;
            run_prev_q <= run_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output

    // one count per unit on the output
    assign held_reference = held_reference_output_q;

endmodule : udr_ramp_top

// *** dv/udr_status_model.sv ***
// behavioural model of the input, timer and supervision status logic
`timescale 1ns/100ps
module udr_status_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [5:0] di_set,
    input wire logic [2:0] tf_set,
    input wire logic [2:0] sv_set,
    input wire logic [15:0] ref_set,
    output logic [5:0] delayed_input_status_word,
    output logic [2:0] timed_status,
    output logic [2:0] supervision_status,
    output logic [15:0] other_reference
);
    // status words change only on a clock edge, as registered logic would
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            delayed_input_status_word <= 6'h00;
            timed_status <= 3'h0;
            supervision_status <= 3'h0;
            other_reference <= 16'h0000;
        end else begin
            delayed_input_status_word <= di_set;
            timed_status <= tf_set;
            supervision_status <= sv_set;
            other_reference <= ref_set;
        end
    end
endmodule : udr_status_model

// *** dv/udr_ramp_assertions.sv ***
// concurrent checks on the ports of the up/down reference ramp
`timescale 1ns/100ps
module udr_ramp_assertions import udr_pkg::*; #(
    parameter int RAMP_UNIT_CYC = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [5:0] delayed_input_status_word,
    input wire logic [2:0] timed_status,
    input wire logic [2:0] supervision_status,
    input wire logic [15:0] held_reference
);
    logic [1:0] mode_q;
    logic [15:0] up_sel_q, dn_sel_q, ramp_q, lo_q, hi_q;
    logic [1:0] quiet_q, age_q, pair_q;
    function automatic logic req_of(input logic [15:0] c);
        if (c == 16'h0001) return 1'b1;
        if (c >= 16'h0002 && c <= 16'h0007) return delayed_input_status_word[c[2:0] - 3'h2];
        if (c >= 16'h0012 && c <= 16'h0014) return timed_status[c[4:0] - 5'h12];
        if (c >= 16'h0018 && c <= 16'h001A) return supervision_status[c[4:0] - 5'h18];
        return 1'b0;
    endfunction : req_of
    wire wr_ok = avs_write && !avs_waitrequest;
    wire up_w = req_of(up_sel_q);
    wire dn_w = req_of(dn_sel_q);
    // steady: mode 2, nonzero ramp time, nothing written lately, requests unchanged for three cycles
    wire steady = quiet_q == 2'h3 && age_q == 2'h3 && mode_q == 2'h2 && ramp_q != 16'h0000;
    ////////////////////////////////////////////////////////////////////////////////
    // register shadows follow committed writes so that rules can be judged at the ports
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {mode_q, up_sel_q, dn_sel_q, quiet_q, age_q, pair_q} <= '0;
            {ramp_q, lo_q, hi_q} <= {16'h0190, 16'hFFCE, 16'h0032};
        end else begin
            if (wr_ok && avs_address == 6'h00) mode_q <= avs_writedata[1:0];
            if (wr_ok && avs_address == 6'h08) up_sel_q <= avs_writedata[15:0];
            if (wr_ok && avs_address == 6'h0C) dn_sel_q <= avs_writedata[15:0];
            if (wr_ok && avs_address == 6'h10) ramp_q <= avs_writedata[15:0];
            if (wr_ok && avs_address == 6'h14) lo_q <= avs_writedata[15:0];
            if (wr_ok && avs_address == 6'h18) hi_q <= avs_writedata[15:0];
            quiet_q <= wr_ok ? 2'h0 : (quiet_q == 2'h3 ? 2'h3 : quiet_q + 2'h1);
            age_q <= ({up_w, dn_w} != pair_q) ? 2'h0 : (age_q == 2'h3 ? 2'h3 : age_q + 2'h1);
            pair_q <= {up_w, dn_w};
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_wait_one_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop after one wait state");
    a_idle_no_wait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && (avs_address > 6'h20 || avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_off_forces_zero: assert property (mode_q == 2'h0 && $past(mode_q) == 2'h0
        |-> held_reference == 16'h0000) else $error("held value nonzero while disabled");
    a_held_in_limits: assert property (quiet_q == 2'h3 && mode_q != 2'h0
        && $signed(lo_q) <= $signed(hi_q) |-> $signed(held_reference) >= $signed(lo_q)
        && $signed(held_reference) <= $signed(hi_q)) else $error("held value outside limits");
    a_both_hold_still: assert property (steady && up_w && dn_w |-> $stable(held_reference))
        else $error("held value moved with both requests");
    a_idle_hold_still: assert property (steady && !up_w && !dn_w |-> $stable(held_reference))
        else $error("held value moved with no request");
    a_up_unit_rise: assert property (steady && up_w && !dn_w |-> held_reference
        == $past(held_reference) || held_reference == $past(held_reference) + 16'h0001)
        else $error("up request gave a wrong step");
    a_down_unit_fall: assert property (steady && dn_w && !up_w |-> held_reference
        == $past(held_reference) || held_reference == $past(held_reference) - 16'h0001)
        else $error("down request gave a wrong step");
    c_up_ramp: cover property (steady && up_w && !dn_w && $changed(held_reference));
    c_down_ramp: cover property (steady && dn_w && !up_w && $changed(held_reference));
    c_both_on: cover property (steady && up_w && dn_w);
endmodule : udr_ramp_assertions

// *** dv/udr_ramp_top_tb.sv ***
// self-checking bench of the up/down reference ramp
`timescale 1ns/100ps
module udr_ramp_top_tb;
    localparam int UNIT = 4;
    logic ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [5:0] avs_address = 6'h00, di_set = 6'h00, delayed_input_status_word;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'hF;
    logic avs_waitrequest;
    logic [2:0] tf_set = 3'h0, sv_set = 3'h0, timed_status, supervision_status;
    logic [15:0] ref_set = 16'h0000, other_reference, held_reference;
    logic [31:0] rst_tab [0:8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0190, 32'hFFCE, 32'h0032,
                                   32'h0, 32'h0};
    int err_count = 0, compares = 0, seed = 62289, n;
    udr_ramp_top #(.RAMP_UNIT_CYC(UNIT)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .delayed_input_status_word(delayed_input_status_word), .timed_status(timed_status),
        .supervision_status(supervision_status), .other_reference(other_reference),
        .held_reference(held_reference));
    udr_status_model i_model (.ref_clk(ref_clk), .rst_n(rst_n), .di_set(di_set),
        .tf_set(tf_set), .sv_set(sv_set), .ref_set(ref_set),
        .delayed_input_status_word(delayed_input_status_word), .timed_status(timed_status),
        .supervision_status(supervision_status), .other_reference(other_reference));
    initial forever #12.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    // one bus cycle; waitrequest and read data are taken at the answering rising edge
    task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin @(posedge ref_clk); end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task chk_near(input string nm, input int exp, input int got);
        compares++;
        if (got < exp - 3 || got > exp + 3) begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_near
    task wait_held(input logic [15:0] v);
        n = 0;
        do begin @(negedge ref_clk); n++; end while (held_reference !== v && n < 400);
        if (held_reference !== v) begin
            err_count++;
            $display("BAD held wait expected %h seen %h", v, held_reference);
        end
    endtask : wait_held
    function automatic logic exp_req(input int c);
        if (c == 1) return 1'b1;
        if (c >= 2 && c <= 7) return di_set[c - 2];
        if (c >= 18 && c <= 20) return tf_set[c - 18];
        if (c >= 24 && c <= 26) return sv_set[c - 24];
        return 1'b0;
    endfunction : exp_req
    task close_out;
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (50000) @(posedge ref_clk);
        err_count++;
        close_out;
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, 6'(i * 4), 32'h0);
            chk("reset value", rst_tab[i], rd);
        end
        chk("held after reset", 32'h0, {16'h0, held_reference});
        $display("test reset values done");
        // random status words under every selector code on both paths
        for (int c = 0; c < 32; c++) begin
            @(posedge ref_clk);
            di_set <= 6'($random(seed));
            tf_set <= 3'($random(seed));
            sv_set <= 3'($random(seed));
            bus(1'b1, 6'h08, 32'(c));
            bus(1'b1, 6'h0C, 32'(c));
            bus(1'b0, 6'h20, 32'h0);
            chk("up request", {31'h0, exp_req(c)}, {31'h0, rd[8]});
            chk("down request", {31'h0, exp_req(c)}, {31'h0, rd[9]});
        end
        $display("test selector decode done");
        // span 10 over ramp 5 counts: full travel takes 5 * UNIT cycles either way
        bus(1'b1, 6'h08, 32'h0);
        bus(1'b1, 6'h0C, 32'h0);
        bus(1'b1, 6'h14, 32'h0);
        bus(1'b1, 6'h18, 32'h000A);
        bus(1'b1, 6'h10, 32'h0005);
        bus(1'b1, 6'h00, 32'h0002);
        bus(1'b1, 6'h20, 32'h0003);
        bus(1'b1, 6'h08, 32'h0001);
        wait_held(16'h000A);
        chk_near("rise cycles", 5 * UNIT, n);
        bus(1'b1, 6'h0C, 32'h0001);
        repeat (30) @(negedge ref_clk);
        chk("held both on", 32'h000A, {16'h0, held_reference});
        bus(1'b1, 6'h08, 32'h0000);
        wait_held(16'h0000);
        chk_near("fall cycles", 5 * UNIT, n);
        repeat (20) @(negedge ref_clk);
        chk("held at lower", 32'h0, {16'h0, held_reference});
        bus(1'b1, 6'h14, 32'h0003);
        repeat (4) @(negedge ref_clk);
        chk("raised lower", 32'h0003, {16'h0, held_reference});
        bus(1'b1, 6'h08, 32'h0001);
        repeat (30) @(negedge ref_clk);
        chk("held both at lower", 32'h0003, {16'h0, held_reference});
        bus(1'b1, 6'h08, 32'h0000);
        $display("test ramp and limits done");
        // track the other reference, then hold it once reselected
        bus(1'b1, 6'h0C, 32'h0000);
        bus(1'b1, 6'h20, 32'h0001);
        bus(1'b1, 6'h00, 32'h0003);
        @(posedge ref_clk) ref_set <= 16'h0064;
        repeat (4) @(negedge ref_clk);
        chk("tracked clamp", 32'h000A, {16'h0, held_reference});
        @(posedge ref_clk) ref_set <= 16'h0005;
        repeat (4) @(negedge ref_clk);
        chk("tracked value", 32'h0005, {16'h0, held_reference});
        bus(1'b1, 6'h20, 32'h0003);
        @(posedge ref_clk) ref_set <= 16'h0008;
        repeat (10) @(negedge ref_clk);
        chk("reselected hold", 32'h0005, {16'h0, held_reference});
        $display("test tracking done");
        // initial value on enable, ramp up, reload on stop
        bus(1'b1, 6'h04, 32'h0007);
        bus(1'b1, 6'h00, 32'h0000);
        bus(1'b1, 6'h00, 32'h0001);
        bus(1'b0, 6'h1C, 32'h0);
        chk("init load", 32'h0007, rd);
        bus(1'b1, 6'h08, 32'h0001);
        wait_held(16'h000A);
        bus(1'b1, 6'h08, 32'h0000);
        bus(1'b1, 6'h20, 32'h0002);
        repeat (3) @(negedge ref_clk);
        chk("stop reload", 32'h0007, {16'h0, held_reference});
        bus(1'b1, 6'h1C, 32'h1234);
        bus(1'b0, 6'h1C, 32'h0);
        chk("held read only", 32'h0007, rd);
        bus(1'b1, 6'h24, 32'hFFFF);
        bus(1'b0, 6'h24, 32'h0);
        chk("unmapped read", 32'h0, rd);
        bus(1'b1, 6'h00, 32'h0000);
        repeat (3) @(negedge ref_clk);
        chk("mode off", 32'h0, {16'h0, held_reference});
        $display("test modes done");
        close_out;
    end
endmodule : udr_ramp_top_tb
bind udr_ramp_top udr_ramp_assertions #(.RAMP_UNIT_CYC(RAMP_UNIT_CYC)) i_chk (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .delayed_input_status_word(delayed_input_status_word),
    .timed_status(timed_status), .supervision_status(supervision_status),
    .held_reference(held_reference));
